// ### common/dsac_pkg.sv
// Constants, types and register map of the dual-slope autorange controller
//*****************************************************************************
// Overview of operation
// - Run-up lasts exactly 1000 clocks, input applied
// - Run-up: reference open, both input switches closed
// - Latch integrator sign at run-up end, show it
// - Run-up end: transfer pulse, count cleared together
// - Run-down: reference closed, one input switch opened
// - Run-down: counter increments every clock
// - Zero crossing: stop, store count, display it
// - Three ranges; count above 1998 steps less sensitive
// - Least range, count 1998 or more: overload
// - Count below 180 steps more sensitive
// - Decimal point follows selected range step
// - Range change holds next conversion 100 ms
// - Display keeps value, updates only on change
// - Generate relay switching pulses for divider decade
//*****************************************************************************
package dsac_pkg;

    //*************************************************************************
    // Counting
    //*************************************************************************
    localparam int          CNT_W        = 12;
    localparam logic [11:0] RUNUP_COUNT  = 12'h3e8; // 1000 clocks
    localparam logic [11:0] OVER_LIMIT   = 12'h7ce; // 1998
    localparam logic [11:0] UNDER_LIMIT  = 12'h0b4; // 180
    localparam logic [11:0] MAX_COUNT    = 12'hfff; // No crossing seen

    //*************************************************************************
    // Range steps and selector positions
    //*************************************************************************
    localparam logic [1:0] RANGE_MOST   = 2'h0;
    localparam logic [1:0] RANGE_LEAST  = 2'h2;
    localparam logic [1:0] SEL_R1000    = 2'h0;
    localparam logic [1:0] SEL_R100     = 2'h1;
    localparam logic [1:0] SEL_R10      = 2'h2;
    localparam logic [1:0] SEL_AUTO     = 2'h3;

    //*************************************************************************
    // Timing
    //*************************************************************************
    localparam int CLK_HZ         = 100000000;
    localparam int SETTLE_TIME_MS = 100;
    localparam int SETTLE_CYCLES  = SETTLE_TIME_MS * (CLK_HZ / 1000);

    //*************************************************************************
    // Register map and fields
    //*************************************************************************
    localparam int          AXI_AW      = 8;
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_STATUS = 8'h04;
    localparam logic [7:0]  ADDR_RESULT = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_ST = 8'h0c;
    localparam logic [7:0]  ADDR_IRQ_EN = 8'h10;
    localparam logic [7:0]  ADDR_IRQ_CL = 8'h14;
    localparam int          CTRL_RUN    = 0;
    localparam logic        CTRL_RESET  = 1'h1;
    localparam int          ST_STATE    = 0;  // 2 bits
    localparam int          ST_RANGE    = 2;  // 2 bits
    localparam int          ST_NEG      = 4;
    localparam int          ST_OVER     = 5;
    localparam int          ST_SEL      = 6;  // 2 bits
    localparam int          IRQ_N       = 3;
    localparam int          IRQ_RESULT  = 0;
    localparam int          IRQ_RANGE   = 1;
    localparam int          IRQ_OVER    = 2;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    //*************************************************************************
    // Types
    //*************************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_RUNUP, ST_RUNDOWN, ST_SETTLE} dsac_state_t;

    typedef struct packed {
        logic reference_switch;
        logic input_switch_a;
        logic input_switch_b;
    } dsac_switch_t;

    typedef struct packed {
        logic [11:0] value;
        logic [1:0]  point;
        logic        negative;
        logic        overload;
    } dsac_display_t;

endpackage

// ### core/dsac_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module dsac_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Pin side and synchronised side
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    // Shift chain; stage1 feeds only stage2
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= pin_i;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Accept a change once stages two and three agree
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            level_o <= '0;
        end else if (stage2 == stage3) begin
            level_o <= stage3;
        end
    end

endmodule // dsac_sync

// ### core/dsac_irq.sv
// Sticky interrupt status with enable and write-one clear
`timescale 1ns/1ns
module dsac_irq #(
    parameter int N = 3
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Events and software access
    input  wire logic [N-1:0] event_i,
    input  wire logic [N-1:0] clear_i,
    input  wire logic [N-1:0] enable_i,
    // Status and request
    output logic      [N-1:0] status_o,
    output logic              irq_o
);

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_o <= '0;
        end else begin
            status_o <= (status_o & ~clear_i) | event_i;
        end
    end

    // Level request while an enabled bit is set
    assign irq_o = |(status_o & enable_i);

endmodule // dsac_irq

// ### core/dsac_top.sv
// Dual-slope conversion sequencer with automatic range selection
`timescale 1ns/1ns
module dsac_top #(
    parameter int          SETTLE_CYCLES = dsac_pkg::SETTLE_CYCLES,
    parameter logic [11:0] RUNUP_COUNT   = dsac_pkg::RUNUP_COUNT
) (
    // Clock and reset
    input  wire logic                  REF_CLK_I,
    input  wire logic                  RST_I,
    // AXI4-Lite write channels
    input  wire logic [7:0]            S_AXI_AWADDR_I,
    input  wire logic                  S_AXI_AWVALID_I,
    output logic                       S_AXI_AWREADY_O,
    input  wire logic [31:0]           S_AXI_WDATA_I,
    input  wire logic [3:0]            S_AXI_WSTRB_I,
    input  wire logic                  S_AXI_WVALID_I,
    output logic                       S_AXI_WREADY_O,
    output logic [1:0]                 S_AXI_BRESP_O,
    output logic                       S_AXI_BVALID_O,
    input  wire logic                  S_AXI_BREADY_I,
    // AXI4-Lite read channels
    input  wire logic [7:0]            S_AXI_ARADDR_I,
    input  wire logic                  S_AXI_ARVALID_I,
    output logic                       S_AXI_ARREADY_O,
    output logic [31:0]                S_AXI_RDATA_O,
    output logic [1:0]                 S_AXI_RRESP_O,
    output logic                       S_AXI_RVALID_O,
    input  wire logic                  S_AXI_RREADY_I,
    // Analogue side
    input  wire logic                  CMP_POSITIVE_I,
    input  wire logic [1:0]            RANGE_SEL_I,
    output dsac_pkg::dsac_switch_t     SWITCH_O,
    output logic                       TRANSFER_O,
    output logic [2:0]                 RELAY_PULSE_O,
    // Display and interrupt
    output dsac_pkg::dsac_display_t    DISPLAY_O,
    output logic                       IRQ_O
);

    //*************************************************************************
    // Declarations
    //*************************************************************************
    dsac_pkg::dsac_state_t state;
    dsac_pkg::dsac_state_t next_state;
    logic [11:0]           count;
    logic [1:0]            range;
    logic [1:0]            next_range;
    logic                  polarity;
    logic                  cmp_positive;
    logic [1:0]            sel;
    logic [31:0]           settle_cnt;
    logic                  run;
    logic                  runup_done;
    logic                  rundown_done;
    logic                  range_change;
    logic                  over_now;
    logic [2:0]            irq_event;
    logic [2:0]            irq_clear;
    logic [2:0]            irq_enable;
    logic [2:0]            irq_status;
    logic                  aw_have;
    logic                  w_have;
    logic [7:0]            aw_addr;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  wr_fire;
    logic [31:0]           rd_word;
    logic                  rd_hit;

    //*************************************************************************
    // Pin synchronisers
    //*************************************************************************
    dsac_sync #(.W(3)) u_sync (
        .clk_i   (REF_CLK_I),
        .rst_i   (RST_I),
        .pin_i   ({CMP_POSITIVE_I, RANGE_SEL_I}),
        .level_o ({cmp_positive, sel})
    );

    //*************************************************************************
    // Conversion sequencing
    //*************************************************************************
    // Phase end conditions
    assign runup_done   = (state == dsac_pkg::ST_RUNUP) && (count == RUNUP_COUNT - 12'h001);
    assign rundown_done = (state == dsac_pkg::ST_RUNDOWN) &&
                          ((cmp_positive != polarity) || (count == dsac_pkg::MAX_COUNT));
    assign range_change = rundown_done && (next_range != range);

    // Range decision on the finished count
    always_comb begin
        next_range = range;
        case (sel)
            dsac_pkg::SEL_R1000: next_range = dsac_pkg::RANGE_LEAST;
            dsac_pkg::SEL_R100:  next_range = 2'h1;
            dsac_pkg::SEL_R10:   next_range = dsac_pkg::RANGE_MOST;
            default: begin
                if (count > dsac_pkg::OVER_LIMIT && range != dsac_pkg::RANGE_LEAST) begin
                    next_range = range + 2'h1;
                end else if (count < dsac_pkg::UNDER_LIMIT && range != dsac_pkg::RANGE_MOST) begin
                    next_range = range - 2'h1;
                end
            end
        endcase
    end

    // Overload on the least sensitive or a forced range
    assign over_now = (count >= dsac_pkg::OVER_LIMIT) &&
                      ((range == dsac_pkg::RANGE_LEAST) || (sel != dsac_pkg::SEL_AUTO));

    // Next phase
    always_comb begin
        next_state = state;
        case (state)
            dsac_pkg::ST_IDLE:   if (run) next_state = dsac_pkg::ST_RUNUP;
            dsac_pkg::ST_RUNUP:  if (runup_done) next_state = dsac_pkg::ST_RUNDOWN;
            dsac_pkg::ST_RUNDOWN: begin
                if (range_change) begin
                    next_state = dsac_pkg::ST_SETTLE;
                end else if (rundown_done) begin
                    next_state = run ? dsac_pkg::ST_RUNUP : dsac_pkg::ST_IDLE;
                end
            end
            dsac_pkg::ST_SETTLE: if (settle_cnt == 32'h0) begin
                next_state = run ? dsac_pkg::ST_RUNUP : dsac_pkg::ST_IDLE;
            end
            default: next_state = dsac_pkg::ST_IDLE;
        endcase
    end

    // Phase register
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state <= dsac_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Clock counter for both slopes
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            count <= 12'h000;
        end else if (runup_done || rundown_done || state == dsac_pkg::ST_IDLE || state == dsac_pkg::ST_SETTLE) begin
            count <= 12'h000;
        end else begin
            count <= count + 12'h001;
        end
    end

    // Transfer pulse at the end of run-up
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            TRANSFER_O <= 1'b0;
        end else begin
            TRANSFER_O <= runup_done;
        end
    end

    // Integrator sign latched as polarity
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            polarity <= 1'b1;
        end else if (runup_done) begin
            polarity <= cmp_positive;
        end
    end

    // Analogue switch drive
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            SWITCH_O <= '0;
        end else begin
            case (next_state)
                dsac_pkg::ST_RUNUP:   SWITCH_O <= 3'b011;
                dsac_pkg::ST_RUNDOWN: SWITCH_O <= {1'b1, ~(runup_done ? cmp_positive : polarity),
                                                   (runup_done ? cmp_positive : polarity)};
                default:              SWITCH_O <= '0;
            endcase
        end
    end

    //*************************************************************************
    // Range, relay and settle delay
    //*************************************************************************
    // Selected range step
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            range <= dsac_pkg::RANGE_MOST;
        end else if (range_change) begin
            range <= next_range;
        end
    end

    // One-cycle pulse on the relay of the new decade
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            RELAY_PULSE_O <= 3'h0;
        end else begin
            RELAY_PULSE_O <= range_change ? (3'h1 << next_range) : 3'h0;
        end
    end

    // Settle delay counter
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            settle_cnt <= 32'h0;
        end else if (range_change) begin
            settle_cnt <= 32'(SETTLE_CYCLES - 1);
        end else if (state == dsac_pkg::ST_SETTLE && settle_cnt != 32'h0) begin
            settle_cnt <= settle_cnt - 32'h1;
        end
    end

    //*************************************************************************
    // Display memory
    //*************************************************************************
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            DISPLAY_O <= '0;
        end else if (rundown_done) begin
            if (count != DISPLAY_O.value) DISPLAY_O.value <= count;
            DISPLAY_O.point    <= range;
            DISPLAY_O.negative <= ~polarity;
            DISPLAY_O.overload <= over_now;
        end
    end

    //*************************************************************************
    // Interrupts
    //*************************************************************************
    assign irq_event[dsac_pkg::IRQ_RESULT] = rundown_done && (count != DISPLAY_O.value);
    assign irq_event[dsac_pkg::IRQ_RANGE]  = range_change;
    assign irq_event[dsac_pkg::IRQ_OVER]   = rundown_done && over_now;
    assign irq_clear = (wr_fire && aw_addr == dsac_pkg::ADDR_IRQ_CL && w_strb[0]) ? w_data[2:0] : 3'h0;

    dsac_irq #(.N(dsac_pkg::IRQ_N)) u_irq (
        .clk_i    (REF_CLK_I),
        .rst_i    (RST_I),
        .event_i  (irq_event),
        .clear_i  (irq_clear),
        .enable_i (irq_enable),
        .status_o (irq_status),
        .irq_o    (IRQ_O)
    );

    //*************************************************************************
    // AXI4-Lite write path
    //*************************************************************************
    assign S_AXI_AWREADY_O = !aw_have && !S_AXI_BVALID_O;
    assign S_AXI_WREADY_O  = !w_have && !S_AXI_BVALID_O;
    assign wr_fire         = aw_have && w_have;

    // Capture address and data in either order
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            aw_have <= 1'b0;
            w_have  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
        end else begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_have <= 1'b1;
                aw_addr <= S_AXI_AWADDR_I;
            end else if (wr_fire) begin
                aw_have <= 1'b0;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_have <= 1'b1;
                w_data <= S_AXI_WDATA_I;
                w_strb <= S_AXI_WSTRB_I;
            end else if (wr_fire) begin
                w_have <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O  <= dsac_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O  <= (aw_addr == dsac_pkg::ADDR_CTRL || aw_addr == dsac_pkg::ADDR_IRQ_EN ||
                               aw_addr == dsac_pkg::ADDR_IRQ_CL) ? dsac_pkg::RESP_OKAY : dsac_pkg::RESP_SLVERR;
        end else if (S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
        end
    end

    // Control and enable registers
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            run        <= dsac_pkg::CTRL_RESET;
            irq_enable <= 3'h0;
        end else if (wr_fire && w_strb[0]) begin
            if (aw_addr == dsac_pkg::ADDR_CTRL) run <= w_data[dsac_pkg::CTRL_RUN];
            if (aw_addr == dsac_pkg::ADDR_IRQ_EN) irq_enable <= w_data[2:0];
        end
    end

    //*************************************************************************
    // AXI4-Lite read path
    //*************************************************************************
    always_comb begin
        rd_word = 32'h0;
        rd_hit  = 1'b1;
        case (S_AXI_ARADDR_I)
            dsac_pkg::ADDR_CTRL:   rd_word = {31'h0, run};
            dsac_pkg::ADDR_STATUS: rd_word = {24'h0, sel, over_now && rundown_done, ~polarity, range, state};
            dsac_pkg::ADDR_RESULT: rd_word = {16'h0, DISPLAY_O};
            dsac_pkg::ADDR_IRQ_ST: rd_word = {29'h0, irq_status};
            dsac_pkg::ADDR_IRQ_EN: rd_word = {29'h0, irq_enable};
            dsac_pkg::ADDR_IRQ_CL: rd_word = 32'h0;
            default:               rd_hit  = 1'b0;
        endcase
    end

    assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;

    // Read data register
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O  <= 32'h0;
            S_AXI_RRESP_O  <= dsac_pkg::RESP_OKAY;
        end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RDATA_O  <= rd_word;
            S_AXI_RRESP_O  <= rd_hit ? dsac_pkg::RESP_OKAY : dsac_pkg::RESP_SLVERR;
        end else if (S_AXI_RREADY_I) begin
            S_AXI_RVALID_O <= 1'b0;
        end
    end

endmodule // dsac_top

// ### tb/dsac_top_chk.sv
// Port-level assertions for the conversion sequencer
`timescale 1ns/1ns
module dsac_top_chk #(
    parameter logic [11:0] RUNUP_COUNT = dsac_pkg::RUNUP_COUNT
) (
    // Clock and reset
    input wire logic                    REF_CLK_I,
    input wire logic                    RST_I,
    // Watched outputs
    input wire dsac_pkg::dsac_switch_t  SWITCH_O,
    input wire logic                    TRANSFER_O,
    input wire logic [2:0]              RELAY_PULSE_O,
    input wire dsac_pkg::dsac_display_t DISPLAY_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    logic [11:0] run_len; // Cycles spent integrating upward
    // Run-up length counter
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) run_len <= 12'h000;
        else run_len <= (SWITCH_O == 3'h3) ? run_len + 12'h001 : 12'h000;
    end
    // Relay pulse and settle steps
    sequence s_pulse; $onehot(RELAY_PULSE_O) ##1 RELAY_PULSE_O == 3'h0; endsequence
    sequence s_hold; (SWITCH_O != 3'h3) [*8]; endsequence
    property p_len; $past(SWITCH_O) == 3'h3 && SWITCH_O != 3'h3 |-> run_len == RUNUP_COUNT; endproperty
    property p_up; SWITCH_O.input_switch_a && SWITCH_O.input_switch_b |-> !SWITCH_O.reference_switch; endproperty
    property p_xfer; $rose(SWITCH_O.reference_switch) |-> ##[0:1] TRANSFER_O; endproperty
    property p_down; SWITCH_O.reference_switch |-> SWITCH_O.input_switch_a != SWITCH_O.input_switch_b; endproperty
    property p_sign;
        $fell(SWITCH_O.reference_switch) |-> ##1 DISPLAY_O.negative == $past(SWITCH_O.input_switch_a, 2);
    endproperty
    property p_over; DISPLAY_O.overload |-> DISPLAY_O.value >= dsac_pkg::OVER_LIMIT; endproperty
    property p_relay; |RELAY_PULSE_O |-> s_pulse; endproperty
    property p_settle; |RELAY_PULSE_O |-> s_hold; endproperty
    a_len: assert property (p_len) else $error("run-up length");
    a_up: assert property (p_up) else $error("run-up switches");
    a_xfer: assert property (p_xfer) else $error("transfer pulse");
    a_down: assert property (p_down) else $error("run-down switches");
    a_sign: assert property (p_sign) else $error("sign");
    a_over: assert property (p_over) else $error("overload");
    a_relay: assert property (p_relay) else $error("relay pulse");
    a_settle: assert property (p_settle) else $error("settle");
endmodule // dsac_top_chk
bind dsac_top dsac_top_chk #(.RUNUP_COUNT(RUNUP_COUNT)) u_chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
    .SWITCH_O(SWITCH_O), .TRANSFER_O(TRANSFER_O), .RELAY_PULSE_O(RELAY_PULSE_O), .DISPLAY_O(DISPLAY_O));

// ### tb/dsac_integ.sv
// Behavioural integrator with zero comparator
`timescale 1ns/1ns
module dsac_integ (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // Switches and commanded input
    input  wire dsac_pkg::dsac_switch_t sw_i,
    input  wire logic                   pos_i,
    input  wire logic [11:0]            len_i,
    // Comparator
    output logic                        cmp_o
);
    logic [11:0] dis; // Run-down cycles so far
    // Discharge timer
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) dis <= 12'h000;
        else dis <= sw_i.reference_switch ? dis + 12'h001 : 12'h000;
    end
    // Sign flips once the charge is gone
    assign cmp_o = (sw_i.reference_switch && dis >= len_i) ? !pos_i : pos_i;
endmodule // dsac_integ

// ### tb/dual_slope_autorange_control_test.sv
// Self-checking bench for the dual-slope autorange controller
`timescale 1ns/1ns
module dual_slope_autorange_control_test;
    logic        clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, pos = 1, en = 0;
    logic        awr, wrr, bv, arr, rv, irq, cmp;
    logic [7:0]  awa = '0, ara = '0;
    logic [31:0] wd = '0, rdd, v;
    logic [1:0]  br, rr, r, sel = 2'h3;
    logic [11:0] len = 12'h3e8;
    dsac_pkg::dsac_switch_t  sw;
    dsac_pkg::dsac_display_t disp;
    int miscompares = 0, check_count = 0, cyc = 0, rng = 0;
    logic [11:0] lt [13] = '{0, 12'h9c4, 12'h064, 12'h9c4, 12'h9c4, 12'h9c4, 12'h032, 12'h032, 12'h032, 0, 0, 12'h9c4, 0};
    logic [1:0]  st [13] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h0, 2'h0, 2'h1, 2'h2};
    //********
    // Design and partner
    //********
    dsac_top #(.SETTLE_CYCLES(20)) u_dut (.REF_CLK_I(clk), .RST_I(rst),
        .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
        .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrr), .S_AXI_BRESP_O(br),
        .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
        .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv),
        .S_AXI_RREADY_I(rre), .CMP_POSITIVE_I(cmp), .RANGE_SEL_I(sel), .SWITCH_O(sw), .TRANSFER_O(),
        .RELAY_PULSE_O(), .DISPLAY_O(disp), .IRQ_O(irq));
    dsac_integ u_integ (.clk_i(clk), .rst_i(rst), .sw_i(sw), .pos_i(pos), .len_i(len), .cmp_o(cmp));
    // Clock and hang limit
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            miscompares++;
            results();
        end
    end
    // One comparison
    task automatic chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask
    // Verdict and end of run
    task automatic results();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One AXI4-Lite write or read, read data left in v
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic ta, tw, tr, done;
        done = 1'b0;
        @(posedge clk);
        if (w) {awa, wd, awv, wv, bre} <= {a, d, 3'h7};
        else {ara, arv, rre} <= {a, 2'h3};
        while (!done) begin
            @(negedge clk);
            {ta, tw, tr} = {awv && awr, wv && wrr, arv && arr};
            {done, resp, v} = w ? {bv, br, v} : {rv, rr, rdd};
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (tr) arv <= 1'b0;
        end
        {bre, rre} <= 2'h0;
    endtask
    // One conversion against the range model
    task automatic conv(input logic [11:0] l, input logic [1:0] s);
        logic p;
        int nr;
        p = 1'($urandom % 2);
        {pos, len, sel} <= {p, l, s};
        do @(posedge clk); while (sw.reference_switch !== 1'b1);
        do @(posedge clk); while (sw.reference_switch !== 1'b0);
        repeat (2) @(negedge clk);
        chk(disp.value >= l && disp.value <= l + 12'h008, "count");
        chk(disp.point === 2'(rng), "point");
        chk(disp.negative === !p, "sign");
        chk(disp.overload === (l >= dsac_pkg::OVER_LIMIT && (rng == 2 || s != 2'h3)), "overload");
        nr = s == 2'h0 ? 2 : s == 2'h1 ? 1 : s == 2'h2 ? 0 : (l > dsac_pkg::OVER_LIMIT && rng < 2) ? rng + 1 :
            (l < dsac_pkg::UNDER_LIMIT && rng > 0) ? rng - 1 : rng;
        chk(irq === (en && nr != rng), "irq");
        rng = nr;
        bus(1, dsac_pkg::ADDR_IRQ_CL, 32'h7, r);
    endtask
    // Main sequence
    initial begin
        void'($urandom(32'h085bc76c));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        bus(0, dsac_pkg::ADDR_CTRL, 0, r);
        chk(v[0] === 1'b1 && r === dsac_pkg::RESP_OKAY, "ctrl reset");
        bus(0, 8'h40, 0, r);
        chk(r === dsac_pkg::RESP_SLVERR, "unmapped");
        bus(1, dsac_pkg::ADDR_STATUS, 0, r);
        chk(r === dsac_pkg::RESP_SLVERR, "read-only");
        bus(1, dsac_pkg::ADDR_IRQ_EN, 32'h2, r);
        en = 1'b1;
        for (int i = 0; i < 13; i++) begin
            if (i == 7) begin
                bus(1, dsac_pkg::ADDR_IRQ_EN, 0, r);
                en = 1'b0;
            end
            conv(lt[i] == 0 ? 12'(400 + $urandom % 1400) : lt[i], st[i]);
        end
        results();
    end
endmodule // dual_slope_autorange_control_test
